/* File: inc/ubt_pkg.sv */
package ubt_pkg;

  // ==========================================================================
  // Register byte addresses
  localparam logic [4:0] ADDR_COMMAND = 5'h00;
  localparam logic [4:0] ADDR_LINE_CONFIG = 5'h04;
  localparam logic [4:0] ADDR_BIT_RATE_DIVIDER = 5'h08;
  localparam logic [4:0] ADDR_LINE_STATUS = 5'h0c;
  localparam logic [4:0] ADDR_TRANSMIT_HOLDING = 5'h10;
  localparam logic [4:0] ADDR_CARD_RATIO = 5'h14;
  localparam logic [4:0] ADDR_BIPHASE_CONFIG = 5'h18;
  localparam logic [4:0] ADDR_TIMEGUARD = 5'h1c;

  // ==========================================================================
  // Field positions
  localparam int CMD_RECEIVER_SOFT_RESET = 2;
  localparam int CMD_TRANSMITTER_SOFT_RESET = 3;
  localparam int CMD_RECEIVE_ON = 4;
  localparam int CMD_RECEIVE_OFF = 5;
  localparam int CMD_TRANSMIT_ON = 6;
  localparam int CMD_TRANSMIT_OFF = 7;
  localparam int STS_HOLDING_EMPTY = 1;
  localparam int STS_ALL_SENT = 9;
  localparam int STS_RX_ON = 16;
  localparam int STS_TX_ON = 17;
  localparam int HOLD_DELIM_TYPE = 12;
  localparam int BIP_PATTERN_LSB = 8;
  localparam int BIP_POLARITY = 12;

  // ==========================================================================
  // Reset values, mode codes and cycle counts
  localparam logic [10:0] CARD_RATIO_RST = 11'h174;
  localparam logic [2:0] PRESCALE_LAST = 3'h7;
  localparam logic [10:0] SAMPLES_ASYNC = 11'h010;
  localparam logic [15:0] MIN_DIV_SERIAL = 16'h0003;
  localparam logic [15:0] MIN_DIV_SPI = 16'h0006;
  localparam logic [3:0] MODE_CARD = 4'h4;
  localparam logic [3:0] MODE_SPI_A = 4'he;
  localparam logic [3:0] MODE_SPI_B = 4'hf;
  localparam logic [1:0] SRC_PRESCALED = 2'h1;
  localparam logic [1:0] SRC_EXTERNAL = 2'h3;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    TX_IDLE = 3'h0, TX_PRE = 3'h1, TX_DELIM = 3'h3, TX_DATA = 3'h2,
    TX_PAR = 3'h6, TX_STOP = 3'h7, TX_GUARD = 3'h5
  } ubt_tx_state_t;

  typedef struct packed {
    logic single_bit_delimiter;
    logic biphase_enable;
    logic [4:0] rsv_a;
    logic variable_sync;
    logic next_is_command;
    logic [3:0] rsv_b;
    logic clock_output_enable;
    logic nine_bit_select;
    logic high_bit_first;
    logic [1:0] rsv_c;
    logic [1:0] stop_bit_count;
    logic [2:0] check_bit_type;
    logic sync_mode;
    logic [1:0] char_length;
    logic [1:0] clock_source_select;
    logic [3:0] line_mode;
  } ubt_line_cfg_t;

  typedef struct packed {
    ubt_line_cfg_t cfg;
    logic [15:0] clock_divisor;
    logic [10:0] card_rate_ratio;
    logic [3:0] preamble_length;
    logic [1:0] preamble_pattern;
    logic encode_polarity;
    logic [7:0] timeguard;
    logic rx_on;
    logic rx_off_pend;
    logic rx_reset_pulse;
    logic tx_on;
    logic tx_off_pend;
    logic hold_full;
    logic [8:0] hold_data;
    logic hold_sync;
    logic [2:0] presc;
    logic [15:0] cd_cnt;
    logic [10:0] bit_cnt;
    logic sck_in;
    logic sck;
    logic sample;
    logic bit_tick;
    ubt_tx_state_t tx_state;
    logic [8:0] hc;
    logic [8:0] shift;
    logic [3:0] nbits;
    logic parity;
    logic cmd_sync;
    logic txd;
    logic [31:0] rdata;
  } ubt_state_t;

endpackage

/* File: core/ubt_top.sv */
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module ubt_top
  import ubt_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Register port
  input wire logic [4:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Serial clock pin
  input wire logic i_sck,
  output logic o_sck,
  output logic o_sck_oe,
  // Serial data out
  output logic o_txd,
  // Receiver side
  input wire logic i_rx_busy,
  output logic o_rx_enable,
  output logic o_rx_soft_reset,
  output logic o_sample_tick,
  output logic o_bit_tick
);

  ubt_state_t s_q;
  ubt_state_t s_d;

  // ==========================================================================
  // Line helpers

  // Biphase encoding of one bit in the current half; plain NRZ otherwise
  function automatic logic enc(input ubt_state_t s, input logic b);
    return s.cfg.biphase_enable ? (b ^ s.hc[0] ^ s.encode_polarity) : b;
  endfunction

  // Level on the data line for the position the transmitter stands at
  function automatic logic line_level(input ubt_state_t s);
    logic b;
    b = 1'b1;
    case (s.tx_state)
      TX_PRE:
      begin
        case (s.preamble_pattern)
          2'h0: b = 1'b1;
          2'h1: b = 1'b0;
          2'h2: b = ~s.hc[1];
          default: b = s.hc[1];
        endcase
        b = enc(s, b);
      end
      TX_DELIM:
      begin
        if (!s.cfg.biphase_enable)
          b = 1'b0; // Plain start bit
        else if (s.cfg.single_bit_delimiter)
          b = enc(s, 1'b0);
        else
          b = ((s.hc < 9'h003) ~^ s.cmd_sync) ^ s.encode_polarity;
      end
      TX_DATA: b = enc(s, s.shift[s.hc[4:1]]);
      TX_PAR: b = enc(s, s.parity);
      TX_STOP: b = enc(s, 1'b1);
      default: b = 1'b1;
    endcase
    return b;
  endfunction

  // Length of the current frame section in half-bit units
  function automatic logic [8:0] halves(input ubt_state_t s);
    logic [8:0] n;
    n = 9'h002;
    case (s.tx_state)
      TX_PRE: n = {4'h0, s.preamble_length, 1'b0};
      TX_DELIM: n = (s.cfg.biphase_enable && !s.cfg.single_bit_delimiter) ? 9'h006 : 9'h002;
      TX_DATA: n = {4'h0, s.nbits, 1'b0};
      TX_STOP:
      begin
        // Half stop only exists when no serial clock paces the line
        if (s.cfg.stop_bit_count == 2'h1 && !s.cfg.sync_mode)
          n = 9'h003;
        else if (s.cfg.stop_bit_count == 2'h2)
          n = 9'h004;
        else
          n = 9'h002;
      end
      TX_GUARD: n = {s.timeguard, 1'b0};
      default: n = 9'h002;
    endcase
    return n;
  endfunction

  // ==========================================================================
  // Next state
  always_comb
  begin
    logic src_en;
    logic ext_fall;
    logic ext_direct;
    logic master;
    logic spi;
    logic card;
    logic [15:0] cd_eff;
    logic [15:0] min_div;
    logic [10:0] spb;
    logic mid_tick;
    logic hb;
    logic [8:0] step;
    logic [8:0] hc_n;
    logic [3:0] nb;
    logic [8:0] ordered;
    logic [8:0] masked;
    ubt_tx_state_t nxt;
    src_en = 1'b1;
    ext_fall = 1'b0;
    ext_direct = 1'b0;
    master = 1'b0;
    spi = 1'b0;
    card = 1'b0;
    cd_eff = 16'h0000;
    min_div = 16'h0000;
    spb = 11'h000;
    mid_tick = 1'b0;
    hb = 1'b0;
    step = 9'h000;
    hc_n = 9'h000;
    nb = 4'h0;
    ordered = 9'h000;
    masked = 9'h000;
    nxt = TX_IDLE;
    s_d = s_q;
    s_d.rx_reset_pulse = 1'b0;
    s_d.sample = 1'b0;
    s_d.bit_tick = 1'b0;
    s_d.sck_in = i_sck;

    // Source clock selection; the pin is sampled, so it must stay slow
    spi = (s_q.cfg.line_mode == MODE_SPI_A) || (s_q.cfg.line_mode == MODE_SPI_B);
    card = s_q.cfg.line_mode == MODE_CARD;
    ext_fall = s_q.sck_in && !i_sck;
    s_d.presc = s_q.presc + 3'h1;
    if (s_q.cfg.clock_source_select == SRC_PRESCALED)
      src_en = s_q.presc == PRESCALE_LAST;
    else if (s_q.cfg.clock_source_select == SRC_EXTERNAL)
      src_en = ext_fall;
    ext_direct = (s_q.cfg.sync_mode || spi)
               && s_q.cfg.clock_source_select == SRC_EXTERNAL;
    master = (s_q.cfg.sync_mode || spi) && s_q.cfg.clock_output_enable
           && !s_q.cfg.clock_source_select[1];

    // Divisor with the master receive limit applied; zero stops the clock
    min_div = spi ? MIN_DIV_SPI : MIN_DIV_SERIAL;
    cd_eff = s_q.clock_divisor;
    if (master && cd_eff != 16'h0000 && cd_eff < min_div)
      cd_eff = min_div;
    if (ext_direct)
      s_d.sample = ext_fall; // Divisor register ignored
    else if (src_en && cd_eff != 16'h0000)
    begin
      s_d.sample = s_q.cd_cnt >= cd_eff - 16'h0001;
      s_d.cd_cnt = s_d.sample ? 16'h0000 : s_q.cd_cnt + 16'h0001;
    end
    // Low for the first half count, high for the rest; odd divisors are off by one cycle
    s_d.sck = ext_direct ? 1'b0 : (s_d.cd_cnt >= {1'b0, cd_eff[15:1]});

    // Samples per bit: one in clocked mode, card ratio in card mode
    if (card)
      spb = s_q.card_rate_ratio;
    else if (s_q.cfg.sync_mode || spi)
      spb = 11'h001;
    else
      spb = SAMPLES_ASYNC;
    if (s_d.sample && spb != 11'h000)
    begin
      s_d.bit_tick = s_q.bit_cnt >= spb - 11'h001;
      mid_tick = (spb > 11'h001) && (s_q.bit_cnt == {1'b0, spb[10:1]} - 11'h001);
      s_d.bit_cnt = s_d.bit_tick ? 11'h000 : s_q.bit_cnt + 11'h001;
    end
    hb = s_d.bit_tick || mid_tick;
    // Clocked lines advance a whole bit per tick, changing on the falling edge
    step = (spb == 11'h001) ? 9'h002 : 9'h001;

    // Frame sequencer
    if (hb && s_q.tx_state != TX_IDLE)
    begin
      hc_n = s_q.hc + step;
      if (hc_n >= halves(s_q))
      begin
        case (s_q.tx_state)
          TX_PRE: nxt = TX_DELIM;
          TX_DELIM: nxt = TX_DATA;
          TX_DATA: nxt = TX_PAR;
          TX_PAR: nxt = TX_STOP;
          TX_STOP: nxt = TX_GUARD;
          default: nxt = TX_IDLE;
        endcase
        if (nxt == TX_PAR && s_q.cfg.check_bit_type[2])
          nxt = TX_STOP; // No parity
        if (nxt == TX_GUARD && s_q.timeguard == 8'h00)
          nxt = TX_IDLE;
        s_d.tx_state = nxt;
        s_d.hc = 9'h000;
      end
      else
        s_d.hc = hc_n;
    end

    // Load the held character when the previous one has completed
    if (hb && s_d.tx_state == TX_IDLE && s_q.tx_on && s_q.hold_full)
    begin
      nb = s_q.cfg.nine_bit_select ? 4'h9 : 4'h5 + {2'h0, s_q.cfg.char_length};
      for (int i = 0; i < 9; i++)
      begin
        masked[i] = (i < int'(nb)) ? s_q.hold_data[i] : 1'b0;
        if (i < int'(nb))
          ordered[i] = s_q.cfg.high_bit_first ? s_q.hold_data[int'(nb) - 1 - i]
                                              : s_q.hold_data[i];
      end
      s_d.shift = ordered;
      s_d.nbits = nb;
      case (s_q.cfg.check_bit_type)
        3'h0: s_d.parity = ^masked;
        3'h1: s_d.parity = ~^masked;
        3'h2: s_d.parity = 1'b0;
        default: s_d.parity = 1'b1;
      endcase
      s_d.cmd_sync = s_q.cfg.variable_sync ? s_q.hold_sync
                                           : s_q.cfg.next_is_command;
      s_d.hold_full = 1'b0;
      s_d.hc = 9'h000;
      s_d.tx_state = (s_q.cfg.biphase_enable && s_q.preamble_length != 4'h0) ? TX_PRE
                                                                           : TX_DELIM;
    end

    // Pending disables complete once the direction has drained
    if (s_q.rx_off_pend && !i_rx_busy)
    begin
      s_d.rx_on = 1'b0;
      s_d.rx_off_pend = 1'b0;
    end
    if (s_q.tx_off_pend && s_d.tx_state == TX_IDLE && !s_d.hold_full)
    begin
      s_d.tx_on = 1'b0;
      s_d.tx_off_pend = 1'b0;
    end

    // Register writes; configuration is accepted whether enabled or not
    if (i_wr)
    begin
      case (i_addr)
        ADDR_COMMAND:
        begin
          if (i_wdata[CMD_RECEIVE_ON])
          begin
            s_d.rx_on = 1'b1;
            s_d.rx_off_pend = 1'b0;
          end
          if (i_wdata[CMD_RECEIVE_OFF] && s_q.rx_on)
            s_d.rx_off_pend = 1'b1;
          if (i_wdata[CMD_TRANSMIT_ON])
          begin
            s_d.tx_on = 1'b1;
            s_d.tx_off_pend = 1'b0;
          end
          if (i_wdata[CMD_TRANSMIT_OFF] && s_q.tx_on)
            s_d.tx_off_pend = 1'b1;
          if (i_wdata[CMD_RECEIVER_SOFT_RESET])
          begin
            s_d.rx_reset_pulse = 1'b1;
            s_d.rx_off_pend = 1'b0;
          end
          if (i_wdata[CMD_TRANSMITTER_SOFT_RESET])
          begin
            s_d.tx_state = TX_IDLE;
            s_d.hc = 9'h000;
            s_d.hold_full = 1'b0;
            s_d.tx_off_pend = 1'b0;
          end
        end
        ADDR_LINE_CONFIG:
        begin
          s_d.cfg = ubt_line_cfg_t'(i_wdata);
          s_d.cfg.rsv_a = 5'h00;
          s_d.cfg.rsv_b = 4'h0;
          s_d.cfg.rsv_c = 2'h0;
        end
        ADDR_BIT_RATE_DIVIDER: s_d.clock_divisor = i_wdata[15:0];
        ADDR_CARD_RATIO: s_d.card_rate_ratio = i_wdata[10:0];
        ADDR_BIPHASE_CONFIG:
        begin
          s_d.preamble_length = i_wdata[3:0];
          s_d.preamble_pattern = i_wdata[BIP_PATTERN_LSB +: 2];
          s_d.encode_polarity = i_wdata[BIP_POLARITY];
        end
        ADDR_TIMEGUARD: s_d.timeguard = i_wdata[7:0];
        ADDR_TRANSMIT_HOLDING:
        begin
          // Dropped unless the holding register is empty and enabled
          if (s_q.tx_on && !s_q.hold_full)
          begin
            s_d.hold_full = 1'b1;
            s_d.hold_data = i_wdata[8:0];
            s_d.hold_sync = i_wdata[HOLD_DELIM_TYPE];
          end
        end
        default: ;
      endcase
    end

    // Read data stands for exactly the cycle after the strobe
    s_d.rdata = 32'h0000_0000;
    if (i_rd)
    begin
      case (i_addr)
        ADDR_LINE_CONFIG: s_d.rdata = s_q.cfg;
        ADDR_BIT_RATE_DIVIDER: s_d.rdata = {16'h0000, s_q.clock_divisor};
        ADDR_CARD_RATIO: s_d.rdata = {21'h000000, s_q.card_rate_ratio};
        ADDR_BIPHASE_CONFIG:
        begin
          s_d.rdata[3:0] = s_q.preamble_length;
          s_d.rdata[BIP_PATTERN_LSB +: 2] = s_q.preamble_pattern;
          s_d.rdata[BIP_POLARITY] = s_q.encode_polarity;
        end
        ADDR_TIMEGUARD: s_d.rdata = {24'h000000, s_q.timeguard};
        ADDR_LINE_STATUS:
        begin
          // Both flags forced low while the transmitter is off
          s_d.rdata[STS_HOLDING_EMPTY] = s_q.tx_on && !s_q.hold_full;
          s_d.rdata[STS_ALL_SENT] = s_q.tx_on && !s_q.hold_full
                                  && s_q.tx_state == TX_IDLE;
          s_d.rdata[STS_RX_ON] = s_q.rx_on;
          s_d.rdata[STS_TX_ON] = s_q.tx_on;
        end
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end

    s_d.txd = line_level(s_d);
  end

  // ==========================================================================
  // State register
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      s_q <= '0;
      s_q.card_rate_ratio <= CARD_RATIO_RST;
      s_q.txd <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // Outputs
  assign o_rdata = s_q.rdata;
  assign o_txd = s_q.txd;
  assign o_sck = s_q.sck;
  assign o_sck_oe = s_q.cfg.clock_output_enable
                  && s_q.cfg.clock_source_select != SRC_EXTERNAL;
  assign o_rx_enable = s_q.rx_on;
  assign o_rx_soft_reset = s_q.rx_reset_pulse;
  assign o_sample_tick = s_q.sample;
  assign o_bit_tick = s_q.bit_tick;

endmodule

/* File: testbench/ubt_checker_assertions.sv */
`timescale 1ns/1ps
module ubt_checker
  import ubt_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Register port
  input wire logic [4:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  // Serial pins
  input wire logic i_sck,
  input wire logic o_sck,
  input wire logic o_sck_oe,
  input wire logic o_txd,
  // Receiver side
  input wire logic i_rx_busy,
  input wire logic o_rx_enable,
  input wire logic o_rx_soft_reset,
  input wire logic o_sample_tick,
  input wire logic o_bit_tick
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  // ==========
  // Helper decode of command writes
  logic rxon_wr;
  logic rxoff_wr;
  logic rxrst_wr;
  logic [31:0] cfg_q;
  assign rxon_wr = i_wr && i_addr == ADDR_COMMAND && i_wdata[CMD_RECEIVE_ON];
  assign rxoff_wr = i_wr && i_addr == ADDR_COMMAND && i_wdata[CMD_RECEIVE_OFF];
  assign rxrst_wr = i_wr && i_addr == ADDR_COMMAND && i_wdata[CMD_RECEIVER_SOFT_RESET];

  // Shadow of the line configuration, enough to predict the pin enable
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      cfg_q <= '0;
    else if (i_wr && i_addr == ADDR_LINE_CONFIG)
      cfg_q <= i_wdata;
  end

  // ==========
  // Assertions
  a_txd_idle_reset: assert property ($past(i_sys_rst) |-> o_txd)
    else $error("serial line not idle high after reset");
  a_rx_on_cause: assert property ($rose(o_rx_enable) |-> $past(rxon_wr))
    else $error("receiver enabled without a command");
  a_rx_on_effect: assert property (rxon_wr && !i_wdata[CMD_RECEIVE_OFF] |=> o_rx_enable)
    else $error("receiver enable command ignored");
  a_rx_off_waits: assert property (o_rx_enable && i_rx_busy |=> o_rx_enable)
    else $error("receiver stopped in mid character");
  a_rx_off_done: assert property (rxoff_wr ##1 !i_rx_busy |=> !o_rx_enable)
    else $error("receiver disable not completed");
  a_rx_rst_pulse: assert property (rxrst_wr |=> o_rx_soft_reset)
    else $error("receiver soft reset pulse missing");
  a_rx_rst_keeps: assert property (o_rx_soft_reset
    |-> $past(rxrst_wr) && $stable(o_rx_enable))
    else $error("soft reset pulse without cause or enable changed");
  a_clock_pin_drive: assert property (o_sck_oe
    == (cfg_q[18] && cfg_q[5:4] != SRC_EXTERNAL))
    else $error("clock pin enable wrong for source");
  a_read_slot: assert property (!$past(i_rd) |-> o_rdata == '0)
    else $error("read data outside its slot");
endmodule

bind ubt_top ubt_checker chk (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sck(i_sck), .o_sck(o_sck),
  .o_sck_oe(o_sck_oe), .o_txd(o_txd), .i_rx_busy(i_rx_busy), .o_rx_enable(o_rx_enable),
  .o_rx_soft_reset(o_rx_soft_reset), .o_sample_tick(o_sample_tick), .o_bit_tick(o_bit_tick)
);

/* File: testbench/ubt_far_end.sv */
`timescale 1ns/1ps
module ubt_far_end
(
  // System clock and commands from the bench
  input wire logic i_clk,
  input wire logic i_sck_run,
  input wire logic i_go,
  // Far side lines
  output logic o_sck,
  output logic o_busy
);
  int cnt = 0;
  int bcnt = 0;
  logic sck_q = 1'b0;
  logic busy_q = 1'b0;

  // One process owns each line; the ports only mirror it
  assign o_sck = sck_q;
  assign o_busy = busy_q;

  // External clock: still low outside a run, half period four system clocks
  // Receiver busy for thirty cycles after each go, as if a character arrives
  always @(posedge i_clk)
  begin
    cnt <= (i_sck_run && cnt < 3) ? cnt + 1 : 0;
    if (!i_sck_run)
      sck_q <= 1'b0;
    else if (cnt == 3)
      sck_q <= !sck_q;
    bcnt <= i_go ? 30 : (bcnt > 0 ? bcnt - 1 : 0);
    busy_q <= i_go || bcnt > 1;
  end
endmodule

/* File: testbench/test_ubt_top.sv */
`timescale 1ns/1ps
module test_ubt_top import ubt_pkg::*;;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [4:0] i_addr = 5'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic sck_run = 1'b0;
  logic far_go = 1'b0;
  logic [31:0] o_rdata, v;
  logic i_sck, o_sck, o_sck_oe, o_txd, i_rx_busy, o_rx_enable;
  logic o_rx_soft_reset, o_sample_tick, o_bit_tick;
  int fails = 0, n_tests = 0, cyc = 0, d, t, h, k;
  int q[$];
  int pl[5] = '{0, 1, 15, 3, 2};
  int pp[5] = '{0, 0, 2, 3, 1};
  int pol[5] = '{0, 0, 0, 1, 0};
  int nic[5] = '{0, 1, 0, 0, 1};
  int hs[5] = '{0, 0, 0, 1, 0};
  int dl[5] = '{0, 1, 2, 1, 2};
  // Status of an enabled transmitter with nothing queued
  localparam logic [31:0] ST_IDLE = 32'((1 << STS_HOLDING_EMPTY) | (1 << STS_ALL_SENT)
                                        | (1 << STS_TX_ON));

  always #5 i_clk = !i_clk;

  ubt_top uut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sck(i_sck), .o_sck(o_sck),
    .o_sck_oe(o_sck_oe), .o_txd(o_txd), .i_rx_busy(i_rx_busy), .o_rx_enable(o_rx_enable),
    .o_rx_soft_reset(o_rx_soft_reset), .o_sample_tick(o_sample_tick), .o_bit_tick(o_bit_tick)
  );
  ubt_far_end far (
    .i_clk(i_clk), .i_sck_run(sck_run), .i_go(far_go), .o_sck(i_sck), .o_busy(i_rx_busy)
  );

  // ==========
  // Reporting
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // ==========
  // Register port; a gap cycle keeps each strobe from being driven twice at one edge
  task automatic wr(input logic [4:0] a, input logic [31:0] dt);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= dt;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] dt);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 dt = o_rdata;
    @(posedge i_clk);
  endtask

  // Sample ticks, clock-pin highs and bit ticks over n cycles, read once settled
  task automatic cnt(input int n, output int tc, output int hc, output int bc);
    tc = 0;
    hc = 0;
    bc = 0;
    repeat (n)
    begin
      @(posedge i_clk);
      #1;
      tc += o_sample_tick;
      hc += o_sck;
      bc += o_bit_tick;
    end
  endtask

  // Falling edges of the serial line over n cycles
  task automatic falls(input int n, output int kc);
    logic last;
    kc = 0;
    last = 1'b1;
    repeat (n)
    begin
      @(posedge i_clk);
      #1;
      kc += (last && !o_txd);
      last = o_txd;
    end
  endtask

  // ==========
  // Reference model: a frame as a list of half-bit levels
  task automatic put(input int b, input int enc, input int pl_x);
    q.push_back(enc ? b ^ pl_x : b);
    q.push_back(enc ? !b ^ pl_x : b);
  endtask

  task automatic model(input int dt, nb, par, msb, bip, px, pln, ppn, dln);
    int p;
    p = 0;
    q = {};
    for (int i = 0; i < pln; i++)
      put(ppn == 0 ? 1 : ppn == 1 ? 0 : (i % 2) ^ (ppn == 2), 1, px);
    if (bip && dln > 0)
      for (int i = 0; i < 6; i++)
        q.push_back((i < 3) ^ (dln == 2) ^ px);
    else
      put(0, bip, px);
    for (int i = 0; i < nb; i++)
    begin
      put((dt >> (msb ? nb - 1 - i : i)) & 1, bip, px);
      p ^= (dt >> i) & 1;
    end
    if (par < 4)
      put(par == 0 ? p : par == 1 ? !p : par == 3, bip, px);
    put(1, bip, px);
  endtask

  function automatic logic [31:0] lc(input int nb, par, msb, bip, ob, nc, vs);
    return {ob[0], bip[0], 5'h0, vs[0], nc[0], 4'h0, 1'b0, nb == 9, msb[0], 4'h0,
      par[2:0], 1'b0, nb == 9 ? 2'h3 : 2'(nb - 5), 6'h0};
  endfunction

  // Idle leads the frame, so align on the first low half, then sample mid-half
  task automatic cap(input string nm);
    int i, w;
    i = 0;
    w = 0;
    while (q[i] == 1)
      i++;
    // Step off the edge so the line is read after it has settled
    #1;
    while (o_txd !== 1'b0 && w < 3000)
    begin
      @(posedge i_clk);
      #1;
      w++;
    end
    chk("frame_start", w < 3000, 1);
    for (int j = i; j < q.size(); j++)
    begin
      repeat (j == i ? 4 : 8) @(posedge i_clk);
      #1;
      chk(nm, o_txd, q[j]);
    end
    repeat (40) @(posedge i_clk);
  endtask

  // ==========
  // Main sequence
  initial
  begin
    void'($urandom(96));
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    rd(ADDR_CARD_RATIO, v);
    chk("card_ratio", v, 32'h174);
    rd(ADDR_LINE_STATUS, v);
    chk("status_rst", v, 32'h0);
    wr(ADDR_BIT_RATE_DIVIDER, 32'h1);
    wr(ADDR_LINE_CONFIG, lc(8, 4, 0, 0, 0, 0, 0));
    wr(ADDR_TRANSMIT_HOLDING, 32'h0);
    repeat (100) @(posedge i_clk);
    chk("txd_off", o_txd, 1);
    rd(5'h13, v);
    chk("unmapped", v, 32'h0);
    wr(ADDR_COMMAND, 32'h1 << CMD_TRANSMIT_ON);
    rd(ADDR_LINE_STATUS, v);
    chk("status_on", v, ST_IDLE);
    $display("end of reset test");
    // Parity codes zero to four, lengths five to nine, both bit orders
    for (int pr = 0; pr < 5; pr++)
    begin
      d = $urandom & ((1 << (5 + pr)) - 1);
      wr(ADDR_LINE_CONFIG, lc(5 + pr, pr, pr % 2, 0, 0, 0, 0));
      model(d, 5 + pr, pr, pr % 2, 0, 0, 0, 0, 0);
      wr(ADDR_TRANSMIT_HOLDING, d);
      cap("plain_bit");
    end
    $display("end of plain frame test");
    // Biphase: preambles, delimiters, sync sources, polarity
    for (int b = 0; b < 5; b++)
    begin
      d = b == 0 ? 32'hb1 : $urandom & 32'hff;
      wr(ADDR_LINE_CONFIG, lc(8, 4, 1, 1, b == 0, nic[b], b > 2));
      wr(ADDR_BIPHASE_CONFIG, pl[b] | pp[b] << BIP_PATTERN_LSB | pol[b] << BIP_POLARITY);
      model(d, 8, 4, 1, 1, pol[b], pl[b], pp[b], dl[b]);
      wr(ADDR_TRANSMIT_HOLDING, d | hs[b] << HOLD_DELIM_TYPE);
      cap("biphase_half");
    end
    $display("end of biphase test");
    // Two characters queued, a third dropped, disable drains the queue
    wr(ADDR_LINE_CONFIG, lc(8, 4, 0, 0, 0, 0, 0));
    wr(ADDR_TRANSMIT_HOLDING, 32'hff);
    repeat (20) @(posedge i_clk);
    rd(ADDR_LINE_STATUS, v);
    chk("status_busy", v, (1 << STS_HOLDING_EMPTY) | (1 << STS_TX_ON));
    wr(ADDR_TRANSMIT_HOLDING, 32'hff);
    rd(ADDR_LINE_STATUS, v);
    chk("status_full", v, 1 << STS_TX_ON);
    wr(ADDR_TRANSMIT_HOLDING, 32'h0);
    wr(ADDR_COMMAND, 32'h1 << CMD_TRANSMIT_OFF);
    falls(600, k);
    chk("drain_frames", k, 1);
    rd(ADDR_LINE_STATUS, v);
    chk("status_off", v, 32'h0);
    $display("end of drain test");
    // Soft reset in mid character
    wr(ADDR_COMMAND, 32'h1 << CMD_TRANSMIT_ON);
    wr(ADDR_TRANSMIT_HOLDING, 32'h0);
    repeat (40) @(posedge i_clk);
    wr(ADDR_COMMAND, 32'h1 << CMD_TRANSMITTER_SOFT_RESET);
    chk("reset_txd", o_txd, 1);
    rd(ADDR_LINE_CONFIG, v);
    chk("reset_cfg", v, lc(8, 4, 0, 0, 0, 0, 0));
    rd(ADDR_LINE_STATUS, v);
    chk("reset_flags", v, ST_IDLE);
    $display("end of soft reset test");
    // Receiver enable, disable during a character, soft reset
    wr(ADDR_COMMAND, 32'h1 << CMD_RECEIVE_ON);
    chk("rx_on", o_rx_enable, 1);
    far_go <= 1'b1;
    @(posedge i_clk);
    far_go <= 1'b0;
    wr(ADDR_COMMAND, 32'h1 << CMD_RECEIVE_OFF);
    repeat (10) @(posedge i_clk);
    chk("rx_held", o_rx_enable, 1);
    repeat (30) @(posedge i_clk);
    chk("rx_off", o_rx_enable, 0);
    wr(ADDR_COMMAND, 32'h1 << CMD_RECEIVE_ON);
    wr(ADDR_COMMAND, 32'h1 << CMD_RECEIVE_OFF);
    wr(ADDR_COMMAND, 32'h1 << CMD_RECEIVER_SOFT_RESET);
    $display("end of receiver test");
    // Clocked mode: plain division, master clamp, external pin clock
    wr(ADDR_BIT_RATE_DIVIDER, 32'h8);
    wr(ADDR_LINE_CONFIG, 32'h40100);
    cnt(80, t, h, k);
    chk("sync_ticks", t >= 9 && t <= 11, 1);
    chk("sync_bits", k >= 9 && k <= 11, 1);
    chk("sck_high", h >= 36 && h <= 44, 1);
    chk("sck_drive", o_sck_oe, 1);
    wr(ADDR_BIT_RATE_DIVIDER, 32'h2);
    cnt(90, t, h, k);
    chk("clamp_ticks", t >= 29 && t <= 31, 1);
    wr(ADDR_LINE_CONFIG, 32'h40130);
    sck_run <= 1'b1;
    cnt(80, t, h, k);
    chk("ext_ticks", t >= 9 && t <= 11, 1);
    chk("ext_pin", o_sck_oe, 0);
    sck_run <= 1'b0;
    // Card mode: divisor of two, then a card ratio of five per bit
    wr(ADDR_CARD_RATIO, 32'h5);
    wr(ADDR_LINE_CONFIG, {28'h0000000, MODE_CARD});
    cnt(100, t, h, k);
    chk("card_ticks", t >= 49 && t <= 51, 1);
    chk("card_bits", k >= 9 && k <= 11, 1);
    $display("end of clocked test");
    test_done;
  end

  // Watchdog against a hang
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fails++;
      test_done;
    end
  end
endmodule
